// [cots_field_model.sv]
/*
 * Field side of the selector: a valve motor with position feedback and
 * the wired-OR contact lines that carry the peers' wait flags.
 * Assumes the selector's clock and its direct and reverse relay outputs.
 */
`default_nettype none
module cots_field_model (
   input wire logic clock,
   input wire logic motor_direct,
   input wire logic motor_reverse,
   input wire logic [12:0] peer_a_wait,
   input wire logic [12:0] peer_b_wait,
   output logic [12:0] contact_inputs,
   output logic [9:0] valve_pos = 10'h000
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // Contacts and valve
   // ****************************************************************
   // Any peer in wait pulls the shared contact
   assign contact_inputs = peer_a_wait | peer_b_wait;
   // One step per clock; both relays at once jams the motor
   always @(posedge clock) begin
      if (motor_direct && !motor_reverse && valve_pos < 10'h3e8) begin
         valve_pos <= valve_pos + 10'h001;
      end else if (motor_reverse && !motor_direct && valve_pos != 10'h000) begin
         valve_pos <= valve_pos - 10'h001;
      end
   end
endmodule // cots_field_model
`default_nettype wire

// [cots_pkg.sv]
/*
 * Shared constants and types for the control output type selector.
 * Assumes a single 20 MHz clock and a synchronous active-high reset.
 */
`default_nettype none
package cots_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_HZ = 20000000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = (CLK_HZ / 1000000) * TICK_US;
   localparam int FULL_SCALE = 1000;

   // ****************************************************************
   // Output type selector digit codes
   // ****************************************************************
   localparam logic [7:0] OT_OFF = 8'h00;
   localparam logic [7:0] OT_OUT_VPULSE = 8'h01;
   localparam logic [7:0] OT_OUT_CURRENT = 8'h02;
   localparam logic [7:0] OT_OUT_RELAY = 8'h03;
   localparam logic [7:0] OT_C_RET_VPULSE = 8'h04;
   localparam logic [7:0] OT_C_RET_CURRENT = 8'h05;
   localparam logic [7:0] OT_SECOND_OUTPUT_TERMINAL_RELAY = 8'h06;
   localparam logic [7:0] OT_H_RET_VPULSE = 8'h07;
   localparam logic [7:0] OT_H_RET_CURRENT = 8'h08;

   // ****************************************************************
   // Contact relay codes and flag code
   // ****************************************************************
   localparam logic [13:0] HOLD_SRC_OFF = 14'h0000;
   localparam logic [13:0] DI_STD_FIRST = 14'd5025;
   localparam logic [13:0] DI_STD_LAST = 14'd5027;
   localparam logic [13:0] DI_E1_FIRST = 14'd5041;
   localparam logic [13:0] DI_E1_LAST = 14'd5045;
   localparam logic [13:0] DI_E4_FIRST = 14'd5089;
   localparam logic [13:0] DI_E4_LAST = 14'd5093;
   localparam logic [13:0] WAIT_FLAG_CODE = 14'd4190;
   localparam int NUM_DI = 13;
   localparam int NUM_FSEL = 15;

   // ****************************************************************
   // Control modes and motor commands
   // ****************************************************************
   typedef enum logic [1:0] {
      COTS_MODE_TIME = 2'b00,
      COTS_MODE_ONOFF = 2'b01,
      COTS_MODE_POS_EST = 2'b10,
      COTS_MODE_POS_FB = 2'b11
   } cots_mode_t;

   typedef enum logic [1:0] {
      COTS_MOT_STOP = 2'b00,
      COTS_MOT_DIRECT = 2'b01,
      COTS_MOT_REVERSE = 2'b10
   } cots_mot_t;
endpackage
`default_nettype wire

// [cots_pulse_gen.sv]
/*
 * Time-proportional pulse: on-width = duty/1000 of the cycle time.
 * Assumes the tick input is a one-cycle strobe at the cycle-time unit.
 */
`default_nettype none
module cots_pulse_gen (
   input wire logic clock,
   input wire logic sys_rst,
   cots_pulse_if.gen pif
);
   typedef struct packed {
      logic [15:0] cnt;
      logic pulse;
   } cots_pg_state_t;

   cots_pg_state_t st_q, st_d;
   logic [25:0] on_ticks;

   assign on_ticks = 26'(({10'h000, pif.cycle_ticks} * {16'h0000, pif.duty})
                     / cots_pkg::FULL_SCALE);

   always_comb begin
      st_d = st_q;
      if (pif.tick) begin
         if (st_q.cnt + 16'h0001 >= pif.cycle_ticks) begin
            st_d.cnt = 16'h0000;
         end else begin
            st_d.cnt = st_q.cnt + 16'h0001;
         end
      end
      st_d.pulse = ({10'h000, st_d.cnt} < on_ticks);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pif.pulse = st_q.pulse;

   property p_full_on;
      @(posedge clock) disable iff (sys_rst)
         (pif.duty == 10'd1000 && $stable(pif.duty) && pif.cycle_ticks != 16'h0000)
            |=> pif.pulse;
   endproperty
   a_full_on: assert property (p_full_on) else $error("full duty not on");

   property p_zero_off;
      @(posedge clock) disable iff (sys_rst)
         (pif.duty == 10'd0 && $stable(pif.duty)) |=> !pif.pulse;
   endproperty
   a_zero_off: assert property (p_zero_off) else $error("zero duty not off");
endmodule // cots_pulse_gen
`default_nettype wire

// [cots_pulse_if.sv]
/*
 * Carrier between the selector top and its pulse generator.
 * Assumes both ends share the top's clock.
 */
`default_nettype none
interface cots_pulse_if;
   logic [9:0] duty;
   logic [15:0] cycle_ticks;
   logic tick;
   logic pulse;
   modport gen (input duty, input cycle_ticks, input tick, output pulse);
   modport user (output duty, output cycle_ticks, output tick, input pulse);
endinterface
`default_nettype wire

// [cots_selector.sv]
/*
 * Control output type selector: routes a computation result to the
 * terminal and form picked by the output type code, drives valve motor
 * relays, forces program hold from a contact input and routes the wait
 * flag to alarm, relay and digital outputs.
 * Assumes all inputs are synchronous to clock and settings are static.
 */
`default_nettype none
module cots_selector #(
   parameter int STROKE_TICKS = 100,
   parameter int DEADBAND = 10,
   parameter bit HAS_SECOND_OUTPUT_TERMINAL = 1'b1,
   parameter bit HAS_RET = 1'b1
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [15:0] output_type_select,
   input wire logic [1:0] control_mode,
   input wire logic [9:0] heat_output,
   input wire logic [9:0] cool_output,
   input wire logic [9:0] out_high_limit,
   input wire logic [9:0] out_low_limit,
   input wire logic [15:0] setpoint_value,
   input wire logic [15:0] measured_value,
   input wire logic [15:0] cycle_ticks,
   input wire logic [9:0] valve_feedback,
   input wire logic [13:0] sync_hold_source,
   input wire logic [12:0] contact_inputs,
   input wire logic wait_flag,
   input wire logic [14:0] function_select_wait,
   output logic out_pulse,
   output logic [9:0] out_current,
   output logic second_output_terminal_relay,
   output logic ret_pulse,
   output logic [9:0] ret_current,
   output logic motor_direct,
   output logic motor_reverse,
   output logic [9:0] valve_estimate,
   output logic program_hold,
   output logic hold_source_valid,
   output logic [14:0] function_outputs
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [15:0] tick_cnt;
      logic tick;
      logic out_pulse;
      logic [9:0] out_current;
      logic second_output_terminal_relay;
      logic ret_pulse;
      logic [9:0] ret_current;
      cots_pkg::cots_mot_t mot;
      logic [31:0] stroke_cnt;
      logic [9:0] est;
      logic hold;
      logic hold_valid;
      logic [14:0] fout;
   } cots_state_t;

   cots_state_t st_q, st_d;
   // Full stroke in clocks; accumulate per clock so short strokes keep rate
   localparam int STROKE_CYC = STROKE_TICKS * cots_pkg::TICK_CYC;
   cots_pulse_if heat_if ();
   cots_pulse_if cool_if ();
   logic [7:0] heat_code, cool_code;
   logic [9:0] pos_now, target;
   logic onoff_on;
   logic di_hit;
   logic [12:0] di_sel;

   assign heat_code = output_type_select[7:0];
   assign cool_code = output_type_select[15:8];

   assign heat_if.duty = heat_output;
   assign heat_if.cycle_ticks = cycle_ticks;
   assign heat_if.tick = st_q.tick;
   assign cool_if.duty = cool_output;
   assign cool_if.cycle_ticks = cycle_ticks;
   assign cool_if.tick = st_q.tick;

   cots_pulse_gen u_heat (.clock(clock), .sys_rst(sys_rst), .pif(heat_if.gen));
   cots_pulse_gen u_cool (.clock(clock), .sys_rst(sys_rst), .pif(cool_if.gen));

   assign onoff_on = $signed(measured_value) < $signed(setpoint_value);

   // contact code decode, one per input
   genvar g;
   generate
      for (g = 0; g < cots_pkg::NUM_DI; g++) begin : g_di
         logic [13:0] code;
         if (g < 3) begin : g_std
            assign code = cots_pkg::DI_STD_FIRST + 14'(g);
         end else if (g < 8) begin : g_e1
            assign code = cots_pkg::DI_E1_FIRST + 14'(g - 3);
         end else begin : g_e4
            assign code = cots_pkg::DI_E4_FIRST + 14'(g - 8);
         end
         assign di_sel[g] = (sync_hold_source == code);
      end
   endgenerate
   assign di_hit = |di_sel;

   assign pos_now = (control_mode == cots_pkg::COTS_MODE_POS_FB) ? valve_feedback : st_q.est;
   assign target = heat_output;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic pulse_sel;
      logic [9:0] cur_sel;
      pulse_sel = 1'b0;
      cur_sel = 10'h000;
      st_d = st_q;

      st_d.tick = 1'b0;
      if (st_q.tick_cnt >= 16'(cots_pkg::TICK_CYC - 1)) begin
         st_d.tick_cnt = 16'h0000;
         st_d.tick = 1'b1;
      end else begin
         st_d.tick_cnt = st_q.tick_cnt + 16'h0001;
      end

      pulse_sel = (control_mode == cots_pkg::COTS_MODE_ONOFF) ? onoff_on : heat_if.pulse;
      st_d.out_pulse = 1'b0;
      st_d.out_current = 10'h000;
      st_d.second_output_terminal_relay = 1'b0;
      st_d.ret_pulse = 1'b0;
      st_d.ret_current = 10'h000;

      case (heat_code)
         cots_pkg::OT_OUT_VPULSE, cots_pkg::OT_OUT_RELAY: st_d.out_pulse = pulse_sel;
         cots_pkg::OT_OUT_CURRENT: st_d.out_current = heat_output;
         cots_pkg::OT_SECOND_OUTPUT_TERMINAL_RELAY: st_d.second_output_terminal_relay = HAS_SECOND_OUTPUT_TERMINAL & pulse_sel;
         cots_pkg::OT_H_RET_VPULSE: st_d.ret_pulse = HAS_RET & pulse_sel;
         cots_pkg::OT_H_RET_CURRENT: st_d.ret_current = HAS_RET ? heat_output : 10'h000;
         default: ;
      endcase

      pulse_sel = (control_mode == cots_pkg::COTS_MODE_ONOFF) ? 1'b0 : cool_if.pulse;
      cur_sel = cool_output;
      case (cool_code)
         cots_pkg::OT_OUT_VPULSE, cots_pkg::OT_OUT_RELAY: st_d.out_pulse |= pulse_sel;
         cots_pkg::OT_OUT_CURRENT: st_d.out_current |= cur_sel;
         cots_pkg::OT_SECOND_OUTPUT_TERMINAL_RELAY: st_d.second_output_terminal_relay |= HAS_SECOND_OUTPUT_TERMINAL & pulse_sel;
         cots_pkg::OT_C_RET_VPULSE: st_d.ret_pulse |= HAS_RET & pulse_sel;
         cots_pkg::OT_C_RET_CURRENT: st_d.ret_current |= HAS_RET ? cur_sel : 10'h000;
         default: ;
      endcase

      st_d.mot = cots_pkg::COTS_MOT_STOP;
      if (control_mode[1]) begin
         if (heat_output >= out_high_limit) begin
            st_d.mot = cots_pkg::COTS_MOT_DIRECT;
         end else if (heat_output <= out_low_limit) begin
            st_d.mot = cots_pkg::COTS_MOT_REVERSE;
         end else if (target > pos_now + 10'(DEADBAND)) begin
            st_d.mot = cots_pkg::COTS_MOT_DIRECT;
         end else if (target + 10'(DEADBAND) < pos_now) begin
            st_d.mot = cots_pkg::COTS_MOT_REVERSE;
         end
      end

      // estimate from stroke time
      // Adds 1000 per clock, steps once per full stroke worth, no drift
      if (st_q.mot != cots_pkg::COTS_MOT_STOP) begin
         if (st_q.stroke_cnt + 32'(cots_pkg::FULL_SCALE) >= 32'(STROKE_CYC)) begin
            st_d.stroke_cnt = st_q.stroke_cnt + 32'(cots_pkg::FULL_SCALE)
                              - 32'(STROKE_CYC);
            if (st_q.mot == cots_pkg::COTS_MOT_DIRECT && st_q.est < 10'd1000) begin
               st_d.est = st_q.est + 10'h001;
            end else if (st_q.mot == cots_pkg::COTS_MOT_REVERSE && st_q.est != 10'h000) begin
               st_d.est = st_q.est - 10'h001;
            end
         end else begin
            st_d.stroke_cnt = st_q.stroke_cnt + 32'(cots_pkg::FULL_SCALE);
         end
      end

      st_d.hold_valid = di_hit || (sync_hold_source == cots_pkg::HOLD_SRC_OFF);
      st_d.hold = di_hit && |(di_sel & contact_inputs);

      st_d.fout = function_select_wait & {cots_pkg::NUM_FSEL{wait_flag}};
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign out_pulse = st_q.out_pulse;
   assign out_current = st_q.out_current;
   assign second_output_terminal_relay = st_q.second_output_terminal_relay;
   assign ret_pulse = st_q.ret_pulse;
   assign ret_current = st_q.ret_current;
   // Relay pins are the motor code's own flop bits
   assign motor_direct = st_q.mot[0];
   assign motor_reverse = st_q.mot[1];
   assign valve_estimate = st_q.est;
   assign program_hold = st_q.hold;
   assign hold_source_valid = st_q.hold_valid;
   assign function_outputs = st_q.fout;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_onoff;
      @(posedge clock) disable iff (sys_rst)
         (control_mode == 2'b01 && heat_code == 8'h06)
            |=> second_output_terminal_relay == $past(onoff_on);
   endproperty
   a_onoff: assert property (p_onoff) else $error("on/off output wrong");

   property p_excl;
      @(posedge clock) disable iff (sys_rst) !(motor_direct && motor_reverse);
   endproperty
   a_excl: assert property (p_excl) else $error("both motor relays on");

   property p_mode_stop;
      @(posedge clock) disable iff (sys_rst)
         (!control_mode[1]) |=> (!motor_direct && !motor_reverse);
   endproperty
   a_mode_stop: assert property (p_mode_stop) else $error("relay outside position");

   property p_upper;
      @(posedge clock) disable iff (sys_rst)
         (control_mode[1] && heat_output >= out_high_limit) |=> motor_direct;
   endproperty
   a_upper: assert property (p_upper) else $error("upper limit no direct");

   property p_lower;
      @(posedge clock) disable iff (sys_rst)
         (control_mode[1] && heat_output <= out_low_limit && heat_output < out_high_limit)
            |=> motor_reverse;
   endproperty
   a_lower: assert property (p_lower) else $error("lower limit no reverse");

   property p_est_still;
      @(posedge clock) disable iff (sys_rst)
         (st_q.mot == cots_pkg::COTS_MOT_STOP) |=> $stable(valve_estimate);
   endproperty
   a_est_still: assert property (p_est_still) else $error("estimate moved");

   property p_cur;
      @(posedge clock) disable iff (sys_rst)
         (heat_code == 8'h02 && cool_code == 8'h00) |=> out_current == $past(heat_output);
   endproperty
   a_cur: assert property (p_cur) else $error("current not routed");

   property p_hold;
      @(posedge clock) disable iff (sys_rst)
         (sync_hold_source == 14'd5027 && contact_inputs[2]) |=> program_hold;
   endproperty
   a_hold: assert property (p_hold) else $error("hold not forced");

   property p_bad_src;
      @(posedge clock) disable iff (sys_rst)
         (!di_hit && sync_hold_source != cots_pkg::HOLD_SRC_OFF)
            |=> (!hold_source_valid && !program_hold);
   endproperty
   a_bad_src: assert property (p_bad_src) else $error("bad hold source taken");

   property p_release;
      @(posedge clock) disable iff (sys_rst)
         (contact_inputs == 13'h0000) |=> !program_hold;
   endproperty
   a_release: assert property (p_release) else $error("hold not released");

   property p_wait;
      @(posedge clock) disable iff (sys_rst)
         1'b1 |=> function_outputs == ($past(function_select_wait) & {15{$past(wait_flag)}});
   endproperty
   a_wait: assert property (p_wait) else $error("wait flag misrouted");

   property p_off;
      @(posedge clock) disable iff (sys_rst)
         (output_type_select == 16'h0909) |=> (!out_pulse && !second_output_terminal_relay && !ret_pulse
            && out_current == 10'h000 && ret_current == 10'h000);
   endproperty
   a_off: assert property (p_off) else $error("unlisted code drove output");
endmodule // cots_selector
`default_nettype wire

// [tb_top.sv]
/*
 * Self-checking bench for the output type selector with a field model.
 * Assumes the 20 MHz clock and synchronous reset of the selector.
 */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, sys_rst = 1'b1, wait_flag = 1'b0;
   logic [15:0] ots = 16'h0000, spv = 16'h0000, mv = 16'h0000, cyc = 16'h0002;
   logic [1:0] mode = 2'h0;
   logic [9:0] heat = 10'h3e8, cool = 10'h3e8, hi = 10'h384, lo = 10'h064;
   logic [13:0] hsrc = 14'h0000;
   logic [12:0] peer_a = 13'h0000, peer_b = 13'h0000, contacts;
   logic [14:0] fsel = 15'h0000, fout;
   logic [9:0] vpos, oc, rc, vest, est0;
   logic op, o2, rp, md, mr, hold, hvalid;
   int bad_count = 0, checks_done = 0, cnt;
   localparam logic [15:0] RT_CODE [17] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003,
      16'h0006, 16'h0007, 16'h0008, 16'h0009, 16'h0909, 16'h0100, 16'h0200,
      16'h0300, 16'h0600, 16'h0400, 16'h0500, 16'h0700, 16'h0800};
   localparam logic [4:0] RT_EXP [17] = '{5'h00, 5'h10, 5'h02, 5'h10, 5'h08, 5'h04,
      5'h01, 5'h00, 5'h00, 5'h10, 5'h02, 5'h10, 5'h08, 5'h04, 5'h01, 5'h00, 5'h00};
   localparam logic [13:0] HS_CODE [6] = '{14'h13a1, 14'h13a3, 14'h13b1, 14'h13b5,
      14'h13e1, 14'h13e5};
   localparam int HS_BIT [6] = '{0, 2, 3, 7, 8, 12};
   localparam logic [13:0] BAD_CODE [5] = '{14'h0000, 14'h13a4, 14'h13b0, 14'h105e,
      14'h13e6};
   always #25 clock = ~clock;
   cots_selector #(.STROKE_TICKS(10)) cots_selector_inst (.clock(clock), .sys_rst(sys_rst),
      .output_type_select(ots), .control_mode(mode), .heat_output(heat),
      .cool_output(cool), .out_high_limit(hi), .out_low_limit(lo), .setpoint_value(spv),
      .measured_value(mv), .cycle_ticks(cyc), .valve_feedback(vpos),
      .sync_hold_source(hsrc), .contact_inputs(contacts), .wait_flag(wait_flag),
      .function_select_wait(fsel), .out_pulse(op), .out_current(oc), .second_output_terminal_relay(o2),
      .ret_pulse(rp), .ret_current(rc), .motor_direct(md), .motor_reverse(mr),
      .valve_estimate(vest), .program_hold(hold), .hold_source_valid(hvalid),
      .function_outputs(fout));
   cots_field_model cots_field_model_inst (.clock(clock), .motor_direct(md),
      .motor_reverse(mr), .peer_a_wait(peer_a), .peer_b_wait(peer_b),
      .contact_inputs(contacts), .valve_pos(vpos));
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Whole run is about 45000 cycles
   initial begin
      #(70000 * 50);
      bad_count++;
      print_verdict();
   end
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      step(10);
      chk("reset_levels", 16'h0000, {9'h0, op, o2, rp, md, mr, hold, hvalid});
      chk("reset_values", 16'h0000, {6'h0, oc | rc | vest});
      @(posedge clock) sys_rst <= 1'b0;
      for (int i = 0; i < 17; i++) begin
         @(posedge clock) ots <= RT_CODE[i];
         step(4);
         chk("route_levels", {13'h0, RT_EXP[i][4:2]}, {13'h0, op, o2, rp});
         chk("route_out_cur", RT_EXP[i][1] ? 16'h03e8 : 16'h0000, {6'h0, oc});
         chk("route_ret_cur", RT_EXP[i][0] ? 16'h03e8 : 16'h0000, {6'h0, rc});
      end
      @(posedge clock) begin
         ots <= 16'h0001;
         heat <= 10'h1f4;
      end
      step(4);
      cnt = 0;
      repeat (40000) begin
         step(1);
         if (op === 1'b1) cnt++;
      end
      chk("pulse_on_width", 16'h4e20, (cnt > 19980 && cnt < 20020) ? 16'h4e20 : cnt[15:0]);
      @(posedge clock) begin
         mode <= 2'h1;
         ots <= 16'h0003;
         spv <= 16'h0064;
         mv <= 16'hff9c;
      end
      step(4);
      chk("onoff_below", 16'h0001, {15'h0, op});
      @(posedge clock) mv <= 16'h012c;
      step(4);
      chk("onoff_above", 16'h0000, {15'h0, op});
      @(posedge clock) begin
         ots <= 16'h0006;
         mv <= 16'hff9c;
      end
      step(4);
      chk("onoff_second_output_terminal", 16'h0001, {15'h0, o2});
      @(posedge clock) begin
         mode <= 2'h3;
         ots <= 16'h0000;
      end
      step(3);
      chk("track_direct", 16'h0001, {15'h0, md});
      cnt = 0;
      while ((md === 1'b1 || mr === 1'b1) && cnt < 3000) begin
         if (md === 1'b1 && mr === 1'b1) chk("relays_both", 16'h0000, 16'h0003);
         step(1);
         cnt++;
      end
      chk("valve_tracks", 16'h0001, {15'h0, vpos > 10'h1e6 && vpos < 10'h202});
      @(posedge clock) heat <= 10'h384;
      step(3);
      chk("upper_direct", 16'h0002, {14'h0, md, mr});
      @(posedge clock) heat <= 10'h064;
      step(3);
      chk("lower_reverse", 16'h0001, {14'h0, md, mr});
      @(posedge clock) begin
         mode <= 2'h2;
         heat <= 10'h384;
      end
      step(3);
      est0 = vest;
      step(4000);
      chk("estimate_moves", 16'h0001, {15'h0, vest > est0 || est0 === 10'h3e8});
      chk("estimate_direct", 16'h0002, {14'h0, md, mr});
      for (int i = 0; i < 6; i++) begin
         @(posedge clock) begin
            hsrc <= HS_CODE[i];
            peer_a <= 13'h0001 << HS_BIT[i];
            peer_b <= 13'h0001 << HS_BIT[i];
         end
         step(3);
         chk("hold_valid", 16'h0001, {15'h0, hvalid});
         chk("hold_forced", 16'h0001, {15'h0, hold});
         @(posedge clock) peer_a <= 13'h0000;
         step(3);
         chk("hold_one_peer", 16'h0001, {15'h0, hold});
         @(posedge clock) peer_b <= 13'h0000;
         step(3);
         chk("hold_released", 16'h0000, {15'h0, hold});
      end
      for (int i = 0; i < 5; i++) begin
         @(posedge clock) begin
            hsrc <= BAD_CODE[i];
            peer_a <= 13'h1fff;
         end
         step(3);
         chk("bad_src_valid", {15'h0, i == 0}, {15'h0, hvalid});
         chk("bad_src_hold", 16'h0000, {15'h0, hold});
      end
      @(posedge clock) begin
         fsel <= 15'h4001;
         wait_flag <= 1'b1;
      end
      step(3);
      chk("wait_routed", 16'h4001, {1'b0, fout});
      @(posedge clock) wait_flag <= 1'b0;
      step(3);
      chk("wait_dropped", 16'h0000, {1'b0, fout});
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
